// *** core/dcc_defines.vh ***
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH
// Register indices; byte address is four times the index
`define DCC_IDX_PWR      8'hE8
`define DCC_IDX_OSCSRC   8'hEF
`define DCC_IDX_MEMCTL   8'hD2
`define DCC_IDX_STATUS   8'hF0
`define DCC_ADDR_LSB     2
// Power/clock control fields
`define DCC_PWR_FASTOFF  0
`define DCC_PWR_SLOWON   1
`define DCC_PWR_SEL      2
`define DCC_PWR_DIVLO    3
`define DCC_PWR_DIVHI    4
`define DCC_PWR_T2WAKE   6
`define DCC_PWR_RSVD     5
`define DCC_PWR_PDN      7
`define DCC_PWR_RST      8'h08
// Oscillator source fields
`define DCC_SRC_RC       2
`define DCC_SRC_LOCK     7
`define DCC_SRC_RST      8'h00
// Memory control field
`define DCC_MEM_XRDDIS   4
`define DCC_MEM_RST      8'h00
// Processor clock divisor codes
`define DCC_DIV_2        2'h0
`define DCC_DIV_1        2'h1
`define DCC_DIV_8        2'h2
`define DCC_DIV_256      2'h3
`define DCC_TC_2         8'h01
`define DCC_TC_1         8'h00
`define DCC_TC_8         8'h07
`define DCC_TC_256       8'hFF
// Code space bounds
`define DCC_CODE_LO      24'h000000
`define DCC_CODE_HI      24'h00FFFF
// Access lengths in processor clock periods
`define DCC_RAM_PER      2'h1
`define DCC_CODE_PER     2'h2
// Stabilization delay: 10 ms of 40 MHz cycles
`define DCC_STAB_CYC     19'h61A80
`define DCC_HTRANS_NSEQ  2'h2
`endif

// *** core/dcc_top.v ***
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_top #(
  parameter [18:0] STAB_CYC = `DCC_STAB_CYC
) (
  input  wire        REF_CLK,          // 40 MHz clock
  input  wire        RST_N,            // Synchronous reset
  input  wire        HSEL,             // AHB select
  input  wire [31:0] HADDR,            // AHB address
  input  wire [1:0]  HTRANS,           // AHB transfer type
  input  wire        HWRITE,           // AHB write
  input  wire [2:0]  HSIZE,            // AHB size
  input  wire [31:0] HWDATA,           // AHB write data
  input  wire        HREADY,           // AHB bus ready
  output reg  [31:0] HRDATA,           // AHB read data
  output reg         HREADYOUT,        // AHB slave ready
  output reg         HRESP,            // AHB response
  input  wire        WAKEUP,           // Wakeup event pulse
  input  wire        MAIN_CLK_TICK,    // Edge of main_pll_clock
  input  wire        SLOW_CLK_TICK,    // Edge of slow_internal_clock
  input  wire        SLOW_OSC_STABLE,  // Slow oscillator settled
  input  wire        ACC_REQ,          // Processor access start
  input  wire        ACC_CODE,         // Access is code or data
  input  wire [23:0] MEM_ADDR,         // Code space address
  input  wire        CONST_MOVE_RD,    // Constant-move read
  input  wire        EXT_MOVE_RD,      // External-move read
  output reg         FAST_OSC_EN,      // fast_oscillator enable
  output reg         PLL_EN,           // x4 PLL enable
  output reg         SLOW_OSC_EN,      // slow_oscillator enable
  output reg         SLOW_SRC_RC,      // Slow source is internal RC
  output reg         PCLK_SEL_SLOW,    // Processor on slow clock
  output reg         PCLK_TICK,        // Processor clock pulse
  output reg         ACC_DONE,         // Access complete pulse
  output reg         CODE_RD_STROBE_N, // code_read_strobe
  output reg         FILT_CLK_EN,      // Digital filter clock
  output reg         AFE_CLK_EN,       // Analog front end clock
  output reg         L1_CLK_EN,        // L1 clock
  output reg         T1_CLK_EN,        // Timer 1 clock
  output reg         T3_CLK_EN,        // Timer 3 clock
  output reg         MT_CLK_EN,        // Multitask timer clock
  output reg         T2_CLK_EN,        // Timer 2 clock
  output reg         WDT_CLK_EN,       // Watchdog clock
  output reg         AWU_CLK_EN        // Audio wakeup clock
);

  // ************************************************************
  // Functions
  // ************************************************************
  function [7:0] div_tc;
    input [1:0] code;
    begin
      case (code)
        `DCC_DIV_2: div_tc = `DCC_TC_2;
        `DCC_DIV_1: div_tc = `DCC_TC_1;
        `DCC_DIV_8: div_tc = `DCC_TC_8;
        default:    div_tc = `DCC_TC_256;
      endcase
    end
  endfunction

  function in_code;
    input [23:0] a;
    begin
      in_code = (a >= `DCC_CODE_LO) && (a <= `DCC_CODE_HI);
    end
  endfunction

  // ************************************************************
  // Register bus
  // ************************************************************
  reg  [7:0] pwr;
  reg  [7:0] oscsrc;
  reg  [7:0] memctl;
  reg        wr_pend;
  reg  [7:0] wr_idx;
  reg        stab_busy;
  reg        slow_wait;
  reg  [18:0] stab_cnt;
  wire       addr_ph = HSEL & HREADY & (HTRANS == `DCC_HTRANS_NSEQ);
  wire [7:0] a_idx   = HADDR[`DCC_ADDR_LSB+7:`DCC_ADDR_LSB];
  wire       pdn     = pwr[`DCC_PWR_PDN];
  wire       wr_pwr  = wr_pend & (wr_idx == `DCC_IDX_PWR);
  wire       wr_src  = wr_pend & (wr_idx == `DCC_IDX_OSCSRC);
  wire       wr_mem  = wr_pend & (wr_idx == `DCC_IDX_MEMCTL);
  wire       st_run  = ~stab_busy & ~slow_wait & ~pdn;
  reg  [7:0] rd_val;

  // Read mux; unmapped indices read as zero
  always @* begin
    case (a_idx)
      `DCC_IDX_PWR:    rd_val = pwr;
      `DCC_IDX_OSCSRC: rd_val = oscsrc;
      `DCC_IDX_MEMCTL: rd_val = memctl;
      `DCC_IDX_STATUS: rd_val = {4'h0, st_run, FAST_OSC_EN, slow_wait, stab_busy};
      default:         rd_val = 8'h00;
    endcase
  end

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_idx    <= 8'h00;
      oscsrc    <= `DCC_SRC_RST;
      memctl    <= `DCC_MEM_RST;
    end else begin
      // Zero wait states, response always OKAY
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend <= addr_ph & HWRITE;
      wr_idx  <= a_idx;
      if (addr_ph && !HWRITE)
        HRDATA <= {24'h000000, rd_val};
      if (HSEL && HREADY && !HWRITE && !addr_ph)
        HRDATA <= 32'h00000000;
      // Lock bit is always writable; the source bit obeys the old lock
      if (wr_src) begin
        oscsrc[`DCC_SRC_LOCK] <= HWDATA[`DCC_SRC_LOCK];
        if (!oscsrc[`DCC_SRC_LOCK])
          oscsrc[`DCC_SRC_RC] <= HWDATA[`DCC_SRC_RC];
      end
      if (wr_mem)
        memctl[`DCC_MEM_XRDDIS] <= HWDATA[`DCC_MEM_XRDDIS];
    end
  end

  // ************************************************************
  // Power control, wakeup and stabilization
  // ************************************************************
  reg [7:0] next_pwr;
  always @* begin
    next_pwr = pwr;
    if (wr_pwr) begin
      next_pwr = HWDATA[7:0];
      next_pwr[`DCC_PWR_RSVD] = 1'b0;
    end
    // Wakeup outranks a software write on the same edge
    if (WAKEUP && pdn) begin
      next_pwr[`DCC_PWR_PDN] = 1'b0;
      if (!pwr[`DCC_PWR_SEL])
        next_pwr[`DCC_PWR_FASTOFF] = 1'b0;
      else
        next_pwr[`DCC_PWR_SLOWON] = 1'b1;
    end
  end

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      pwr       <= `DCC_PWR_RST;
      stab_busy <= 1'b0;
      stab_cnt  <= 19'h00000;
      slow_wait <= 1'b0;
    end else begin
      pwr <= next_pwr;
      // Delay only when the fast oscillator was stopped
      if (WAKEUP && pdn && !pwr[`DCC_PWR_SEL] && pwr[`DCC_PWR_FASTOFF]) begin
        stab_busy <= 1'b1;
        stab_cnt  <= STAB_CYC - 19'h00001;
      end else if (stab_busy) begin
        if (stab_cnt == 19'h00000)
          stab_busy <= 1'b0;
        else
          stab_cnt <= stab_cnt - 19'h00001;
      end
      if (WAKEUP && pdn && next_pwr[`DCC_PWR_FASTOFF] && !SLOW_OSC_STABLE)
        slow_wait <= 1'b1;
      else if (SLOW_OSC_STABLE || !next_pwr[`DCC_PWR_FASTOFF])
        slow_wait <= 1'b0;
    end
  end

  // ************************************************************
  // Processor clock select and divide
  // ************************************************************
  reg       sel_act;
  reg [7:0] tc_act;
  reg [7:0] div_cnt;
  reg [1:0] acc_cnt;
  wire      src_tick = sel_act ? SLOW_CLK_TICK : MAIN_CLK_TICK;
  wire      div_end  = src_tick & (div_cnt == tc_act);
  wire      run      = ~pdn & ~stab_busy & ~slow_wait;
  wire      fast_on  = ~pwr[`DCC_PWR_FASTOFF];
  wire      slow_on  = pwr[`DCC_PWR_SLOWON];
  wire      sel_req  = pwr[`DCC_PWR_SEL];
  wire [1:0] div_req = pwr[`DCC_PWR_DIVHI:`DCC_PWR_DIVLO];

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      sel_act   <= 1'b0;
      tc_act    <= `DCC_TC_1;
      div_cnt   <= 8'h00;
      PCLK_TICK <= 1'b0;
      acc_cnt   <= 2'h0;
      ACC_DONE  <= 1'b0;
    end else begin
      if (src_tick)
        div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
      // New source and divisor only at a period boundary
      if (div_end || (div_cnt == 8'h00 && !src_tick)) begin
        sel_act <= sel_req;
        tc_act  <= div_tc(div_req);
      end
      PCLK_TICK <= div_end & run;
      ACC_DONE  <= 1'b0;
      if (ACC_REQ)
        acc_cnt <= ACC_CODE ? `DCC_CODE_PER : `DCC_RAM_PER;
      else if (acc_cnt != 2'h0 && div_end && run) begin
        acc_cnt <= acc_cnt - 2'h1;
        ACC_DONE <= (acc_cnt == 2'h1);
      end
    end
  end

  // ************************************************************
  // Oscillator enables
  // ************************************************************
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      FAST_OSC_EN   <= 1'b1;
      PLL_EN        <= 1'b1;
      SLOW_OSC_EN   <= 1'b0;
      SLOW_SRC_RC   <= 1'b0;
      PCLK_SEL_SLOW <= 1'b0;
    end else begin
      FAST_OSC_EN   <= fast_on;
      PLL_EN        <= fast_on;
      SLOW_OSC_EN   <= slow_on;
      SLOW_SRC_RC   <= oscsrc[`DCC_SRC_RC];
      PCLK_SEL_SLOW <= sel_act;
    end
  end

  // ************************************************************
  // Derived functional clocks
  // ************************************************************
  // Only timer 2 and audio wakeup keep running in power-down
  wire      fast_run = fast_on & ~pdn;
  wire      slow_run = slow_on & ~pdn;

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      FILT_CLK_EN <= 1'b0;
      AFE_CLK_EN  <= 1'b0;
      L1_CLK_EN   <= 1'b0;
      T1_CLK_EN   <= 1'b0;
      T3_CLK_EN   <= 1'b0;
      MT_CLK_EN   <= 1'b0;
      T2_CLK_EN   <= 1'b0;
      WDT_CLK_EN  <= 1'b0;
      AWU_CLK_EN  <= 1'b0;
    end else begin
      FILT_CLK_EN <= fast_run;
      AFE_CLK_EN  <= fast_run;
      L1_CLK_EN   <= fast_run;
      T1_CLK_EN   <= fast_run;
      T3_CLK_EN   <= fast_run;
      MT_CLK_EN   <= fast_run;
      T2_CLK_EN   <= slow_on;
      WDT_CLK_EN  <= slow_run;
      AWU_CLK_EN  <= 1'b1;
    end
  end

  // ************************************************************
  // Code space reads
  // ************************************************************
  // Code space is read-only: there is no write strobe
  wire      code_rd  = in_code(MEM_ADDR) &
                       (CONST_MOVE_RD | (EXT_MOVE_RD & ~memctl[`DCC_MEM_XRDDIS]));

  always @(posedge REF_CLK) begin
    if (!RST_N)
      CODE_RD_STROBE_N <= 1'b1;
    else
      CODE_RD_STROBE_N <= ~code_rd;
  end

endmodule
`default_nettype wire

// *** tb/dcc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// Clock control checks
// ****************
module dcc_props (
  input wire logic        REF_CLK,          // Clock
  input wire logic        RST_N,            // Reset
  input wire logic        FAST_OSC_EN,      // Fast enable
  input wire logic        PLL_EN,           // PLL enable
  input wire logic        SLOW_OSC_EN,      // Slow enable
  input wire logic        PCLK_TICK,        // Processor tick
  input wire logic        FILT_CLK_EN,      // Filter clock
  input wire logic        AFE_CLK_EN,       // AFE clock
  input wire logic        MT_CLK_EN,        // MT clock
  input wire logic        T2_CLK_EN,        // Timer 2 clock
  input wire logic        WDT_CLK_EN,       // Watchdog clock
  input wire logic [23:0] MEM_ADDR,         // Code address
  input wire logic        CONST_MOVE_RD,    // Constant read
  input wire logic        EXT_MOVE_RD,      // External read
  input wire logic        CODE_RD_STROBE_N  // Read strobe
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_pll_follows: assert property (!FAST_OSC_EN |-> !PLL_EN)
    else $error("PLL on with fast oscillator off");
  a_fast_group: assert property ((AFE_CLK_EN == FILT_CLK_EN) && (MT_CLK_EN == FILT_CLK_EN))
    else $error("fast derived clocks disagree");
  a_fast_stop: assert property ($fell(FAST_OSC_EN) |-> ##[0:1] !FILT_CLK_EN)
    else $error("filter clock outlives fast oscillator");
  a_slow_stop: assert property ($fell(SLOW_OSC_EN) |-> ##[0:1] !T2_CLK_EN)
    else $error("timer 2 clock outlives slow oscillator");
  a_wdt_gate: assert property (WDT_CLK_EN |-> T2_CLK_EN)
    else $error("watchdog clock without slow oscillator");
  a_pdn_gate: assert property (FAST_OSC_EN && $past(FAST_OSC_EN) && !FILT_CLK_EN
    && !$past(FILT_CLK_EN) |-> !PCLK_TICK) else $error("processor ticks in power-down");
  a_strobe_low: assert property (CONST_MOVE_RD && (MEM_ADDR <= 24'h00FFFF)
    |=> !CODE_RD_STROBE_N) else $error("constant read not strobed");
  a_strobe_range: assert property ((MEM_ADDR > 24'h00FFFF) |=> CODE_RD_STROBE_N)
    else $error("strobe outside code space");
  a_strobe_idle: assert property (!CONST_MOVE_RD && !EXT_MOVE_RD |=> CODE_RD_STROBE_N)
    else $error("strobe without read");
  c_fast_on: cover property ($rose(FAST_OSC_EN));
  c_slow_on: cover property ($rose(SLOW_OSC_EN));
  c_strobe: cover property (!CODE_RD_STROBE_N);
endmodule
bind dcc_top dcc_props i_props (.*);
`default_nettype wire

// *** tb/dcc_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// Oscillator and PLL model
// ****************
module dcc_osc_model (
  input  wire logic clk,        // Reference clock
  input  wire logic rst_n,      // Reset
  input  wire logic pll_en,     // PLL running
  input  wire logic slow_en,    // Slow oscillator on
  output var  logic main_tick,  // Main clock edge
  output var  logic slow_tick,  // Slow clock edge
  output var  logic slow_stable // Slow oscillator settled
);
  logic [4:0] cnt;
  logic [4:0] age;
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
    main_tick <= rst_n && pll_en && cnt[0];
    slow_tick <= rst_n && slow_en && (cnt[2:0] == 3'h7);
    if (!rst_n || !slow_en) begin
      age <= 5'h00;
    end else if (age != 5'h1F) begin
      age <= age + 5'h01;
    end
    slow_stable <= rst_n && slow_en && (age > 5'h0F);
  end
endmodule
`default_nettype wire

// *** tb/dual_oscillator_clock_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_oscillator_clock_control_tb;
  logic        REF_CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, WAKEUP = 1'b0;
  logic        ACC_REQ = 1'b0, ACC_CODE = 1'b0, CONST_MOVE_RD = 1'b0, EXT_MOVE_RD = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [23:0] MEM_ADDR = 24'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT, HRESP, MAIN_CLK_TICK, SLOW_CLK_TICK, SLOW_OSC_STABLE, ACC_DONE;
  logic        FAST_OSC_EN, PLL_EN, SLOW_OSC_EN, SLOW_SRC_RC, PCLK_SEL_SLOW, PCLK_TICK;
  logic        CODE_RD_STROBE_N, FILT_CLK_EN, AFE_CLK_EN, L1_CLK_EN, T1_CLK_EN, T3_CLK_EN;
  logic        MT_CLK_EN, T2_CLK_EN, WDT_CLK_EN, AWU_CLK_EN;
  wire         HREADY;
  int          n_fail = 0, check_count = 0, tick_cnt = 0;
  assign HREADY = HREADYOUT;
  always #12.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (PCLK_TICK === 1'b1) tick_cnt <= tick_cnt + 1;
  dcc_top #(.STAB_CYC(19'h14)) i_dut (.*);
  dcc_osc_model i_osc (.clk(REF_CLK), .rst_n(RST_N), .pll_en(PLL_EN), .slow_en(SLOW_OSC_EN),
    .main_tick(MAIN_CLK_TICK), .slow_tick(SLOW_CLK_TICK), .slow_stable(SLOW_OSC_STABLE));
  // ****************
  // Bus and check tasks
  // ****************
  task conclude;
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task rdy;
    int n;
    n = 0;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 100) begin
        n_fail++;
        $display("[ERR] %0t bus timeout", $time);
        conclude;
      end
      @(posedge REF_CLK);
    end
  endtask
  task tick_wait;
    int n;
    n = 0;
    @(posedge REF_CLK);
    while (PCLK_TICK !== 1'b1) begin
      n++;
      if (n > 600) begin
        n_fail++;
        $display("[ERR] %0t processor clock timeout", $time);
        conclude;
      end
      @(posedge REF_CLK);
    end
  endtask
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'h2;
    HSEL <= 1'b1;
    rdy;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy;
    q = HRDATA;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task rchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  initial begin
    int t0;
    int d;
    int e;
    int lat[2];
    cyc(10);
    RST_N <= 1'b1;
    rchk(32'h3A0, 32'h08);
    rchk(32'h3BC, 32'h00);
    rchk(32'h000, 32'h00);
    chk({FAST_OSC_EN, PLL_EN, SLOW_OSC_EN, PCLK_SEL_SLOW}, 32'hC);
    chk({HREADYOUT, HRESP}, 32'h2);
    chk({AFE_CLK_EN, L1_CLK_EN, T1_CLK_EN, T3_CLK_EN}, 32'hF);
    for (int i = 0; i < 4; i++) begin
      wr(32'h3A0, {27'h0, i[1:0], 3'h0});
      e = (i == 1) ? 32 : (i == 0) ? 16 : (i == 2) ? 4 : 0;
      cyc(20);
      t0 = tick_cnt;
      cyc(64);
      d = tick_cnt - t0;
      chk(d >= e - 1 && d <= e + 1, 32'h1);
    end
    wr(32'h3A0, 32'h08);
    for (int i = 0; i < 2; i++) begin
      tick_wait;
      ACC_REQ <= 1'b1;
      ACC_CODE <= i[0];
      cyc(1);
      ACC_REQ <= 1'b0;
      d = 0;
      while (ACC_DONE !== 1'b1 && d < 50) begin
        cyc(1);
        d++;
      end
      lat[i] = d;
    end
    chk(lat[1] - lat[0], 32'h2);
    wr(32'h3BC, 32'h04);
    rchk(32'h3BC, 32'h04);
    chk(SLOW_SRC_RC, 32'h1);
    wr(32'h3BC, 32'h84);
    wr(32'h3BC, 32'h80);
    rchk(32'h3BC, 32'h84);
    MEM_ADDR <= 24'h00FFFF;
    CONST_MOVE_RD <= 1'b1;
    cyc(2);
    chk(CODE_RD_STROBE_N, 32'h0);
    MEM_ADDR <= 24'h010000;
    cyc(2);
    chk(CODE_RD_STROBE_N, 32'h1);
    CONST_MOVE_RD <= 1'b0;
    EXT_MOVE_RD <= 1'b1;
    MEM_ADDR <= 24'h000000;
    cyc(2);
    chk(CODE_RD_STROBE_N, 32'h0);
    wr(32'h348, 32'h10);
    cyc(2);
    chk(CODE_RD_STROBE_N, 32'h1);
    EXT_MOVE_RD <= 1'b0;
    wr(32'h3A0, 32'h88);
    cyc(3);
    chk({FAST_OSC_EN, FILT_CLK_EN, AFE_CLK_EN, L1_CLK_EN, T1_CLK_EN, T3_CLK_EN, MT_CLK_EN,
      T2_CLK_EN, AWU_CLK_EN}, 32'h101);
    t0 = tick_cnt;
    cyc(10);
    chk(tick_cnt - t0, 32'h0);
    WAKEUP <= 1'b1;
    cyc(1);
    WAKEUP <= 1'b0;
    t0 = tick_cnt;
    cyc(8);
    chk(tick_cnt - t0 > 1, 32'h1);
    wr(32'h3A0, 32'h8B);
    cyc(3);
    chk({FAST_OSC_EN, PLL_EN, FILT_CLK_EN, MT_CLK_EN, T2_CLK_EN, WDT_CLK_EN, AWU_CLK_EN},
      32'h05);
    t0 = tick_cnt;
    cyc(10);
    chk(tick_cnt - t0, 32'h0);
    WAKEUP <= 1'b1;
    cyc(1);
    WAKEUP <= 1'b0;
    cyc(2);
    chk(FAST_OSC_EN, 32'h1);
    t0 = tick_cnt;
    cyc(14);
    chk(tick_cnt - t0, 32'h0);
    cyc(20);
    chk(tick_cnt - t0 > 0, 32'h1);
    rchk(32'h3A0, 32'h0A);
    wr(32'h3A0, 32'h8D);
    cyc(3);
    WAKEUP <= 1'b1;
    cyc(1);
    WAKEUP <= 1'b0;
    t0 = tick_cnt;
    cyc(12);
    chk(tick_cnt - t0, 32'h0);
    cyc(68);
    chk({SLOW_OSC_EN, PCLK_SEL_SLOW, FAST_OSC_EN}, 32'h6);
    chk(tick_cnt - t0 > 0, 32'h1);
    conclude;
  end
endmodule
`default_nettype wire
